/* File: logic/cdio_cfg_if.sv */
// Configuration write path and configuration readout between port and store
`timescale 1ns/1ps
interface cdio_cfg_if;
    logic               wrReq;    // One-cycle configuration write request
    logic [3:0]         wrIdx;    // Bit index being configured
    cdio_pkg::bit_cfg_t wrCfg;    // New configuration for that bit
    cdio_pkg::cfg_vec_t cfgVec;   // Current configuration of all bits
    logic               refused;  // Pulse: write refused by panel lockout
    logic               rejected; // Pulse: write rejected as inconsistent

    modport port  (output wrReq, wrIdx, wrCfg, input cfgVec, refused, rejected);
    modport store (input wrReq, wrIdx, wrCfg, output cfgVec, refused, rejected);
endinterface : cdio_cfg_if

/* File: logic/cdio_cfg_store.sv */
// Retained per-bit configuration store with pairing and lockout handling
`timescale 1ns/1ps
module cdio_cfg_store (
    input  wire logic               clk_sys,
    input  wire logic               nrst,
    input  wire logic               panelLock,
    input  wire cdio_pkg::cfg_vec_t nvImageIn,
    cdio_cfg_if.store               cfg
);

    // ======================================================================
    // State
    cdio_pkg::store_state_t st_ff;   // Registered state
    cdio_pkg::store_state_t nxt_st;  // Next state

    // Only these functions make sense on an optocoupler pair
    function automatic logic isoOk(input cdio_pkg::func_t f);
        isoOk = (f == cdio_pkg::gp_output) || (f == cdio_pkg::fault_mirror_output) ||
                (f == cdio_pkg::power_loss_output) || (f == cdio_pkg::fault_gated_output);
    endfunction : isoOk

    // ======================================================================
    // Next-state logic for configuration writes
    always_comb begin
        logic [3:0] evenIdx;
        logic [3:0] oddIdx;
        evenIdx        = {cfg.wrIdx[3:1], 1'b0};
        oddIdx         = {cfg.wrIdx[3:1], 1'b1};
        nxt_st         = st_ff;
        nxt_st.refused = 1'b0;
        nxt_st.rejected = 1'b0;
        if (cfg.wrReq) begin
            if (panelLock) begin
                // Lockout: nothing changes, error pulse only
                nxt_st.refused = 1'b1;
            end else if (cfg.wrCfg.isolated && !isoOk(cfg.wrCfg.func)) begin
                // A pair can never be an input
                nxt_st.rejected = 1'b1;
            end else if (cfg.wrCfg.isolated) begin
                // Either bit of a pair configures both
                nxt_st.cfgVec[evenIdx] = cfg.wrCfg;
                nxt_st.cfgVec[oddIdx]  = cfg.wrCfg;
            end else if (cfg.wrIdx[0] && st_ff.cfgVec[evenIdx].isolated) begin
                // Odd half of a live pair cannot leave alone
                nxt_st.rejected = 1'b1;
            end else begin
                // Chassis bits are set one at a time
                nxt_st.cfgVec[cfg.wrIdx] = cfg.wrCfg;
                if (!cfg.wrIdx[0] && st_ff.cfgVec[cfg.wrIdx].isolated) begin
                    // Partner falls back to bidirectional, active low
                    nxt_st.cfgVec[oddIdx].isolated  = 1'b0;
                    nxt_st.cfgVec[oddIdx].activeLow = 1'b1;
                    nxt_st.cfgVec[oddIdx].func = cdio_pkg::gp_bidirectional;
                end
            end
        end
    end

    // ======================================================================
    // Register; reset reloads the retained image rather than a default
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            st_ff.cfgVec   <= nvImageIn;
            st_ff.refused  <= 1'b0;
            st_ff.rejected <= 1'b0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign cfg.cfgVec   = st_ff.cfgVec;
    assign cfg.refused  = st_ff.refused;
    assign cfg.rejected = st_ff.rejected;

endmodule : cdio_cfg_store

/* File: logic/cdio_params.svh */
// Register offsets, field positions and reset values of the digital I/O port
`ifndef CDIO_PARAMS_SVH
`define CDIO_PARAMS_SVH

// ==========================================================================
// Register byte offsets
`define OFS_PORT_DATA   8'h00
`define OFS_CFG_WRITE   8'h04
`define OFS_CFG_INDEX   8'h08
`define OFS_STATUS      8'h0C

// ==========================================================================
// Configuration word field positions
`define CFGF_IDX_LSB    0
`define CFGF_IDX_MSB    3
`define CFGF_FUNC_LSB   4
`define CFGF_FUNC_MSB   7
`define CFGF_POL_BIT    8
`define CFGF_ISO_BIT    9

// ==========================================================================
// Status register bit positions
`define STAT_ACC_BIT    0
`define STAT_REJ_BIT    1
`define STAT_PLOSS_BIT  2
`define STAT_LOCK_BIT   3
`define STAT_FAULT_BIT  4

// ==========================================================================
// Reset values
`define PORT_DATA_RST   16'h0000
`define RDATA_RST       32'h0000_0000
`define CFG_IDX_RST     4'h0

`endif

/* File: logic/cdio_pkg.sv */
// Types shared by the digital I/O port and its configuration store
package cdio_pkg;

    // ======================================================================
    // Per-bit signal function, encoded 0..9 in this order
    typedef enum logic [3:0] {
        gp_input,
        gp_output,
        gp_bidirectional,
        fault_input,
        fault_mirror_output,
        interlock_input,
        trigger_input,
        power_loss_input,
        power_loss_output,
        fault_gated_output
    } func_t;

    // ======================================================================
    // Per-bit configuration: reference, polarity, function
    typedef struct packed {
        logic  isolated;   // 1 = isolated_pair, 0 = chassis_referenced
        logic  activeLow;  // 1 = active_low, 0 = active_high
        func_t func;
    } bit_cfg_t;

    typedef bit_cfg_t [15:0] cfg_vec_t;

    // ======================================================================
    // Configuration store state
    typedef struct packed {
        cfg_vec_t cfgVec;
        logic     refused;
        logic     rejected;
    } store_state_t;

    // ======================================================================
    // Port logic state
    typedef struct packed {
        logic [15:0] portData;
        logic [15:0] pinSamp;
        logic [15:0] pinOut;
        logic [15:0] pinOe;
        logic [31:0] rdata;
        logic [3:0]  cfgIdx;
        logic        powerLoss;
        logic        accErr;
        logic        cfgErr;
        logic        fault;
        logic        interlock;
        logic        trigger;
        logic        pwrIn;
    } port_state_t;

endpackage : cdio_pkg

/* File: logic/configurable_digital_io_port.sv */
// Sixteen-bit configurable digital I/O port with register access
//
// Design decisions made here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`include "cdio_params.svh"

module configurable_digital_io_port (
    input  wire logic               clk_sys,
    input  wire logic               nrst,
    // Register port
    input  wire logic [7:0]         regAddr,
    input  wire logic [31:0]        regWdata,
    input  wire logic               regWr,
    input  wire logic               regRd,
    output logic [31:0]             regRdata,
    // Connector pins, open collector on chassis-referenced bits; isolated pairs drive the even pin to both levels, the odd pin low
    input  wire logic [15:0]        pinIn,
    output logic [15:0]             pinOut,
    output logic [15:0]             pinOe,
    // Instrument side
    input  wire logic               panelLock,
    input  wire logic               genReset,
    input  wire logic               pwrFailSaved,
    input  wire logic               seqStart,
    input  wire logic               restartRecall,
    input  wire cdio_pkg::cfg_vec_t nvImageIn,
    output cdio_pkg::cfg_vec_t      nvImageOut,
    output logic                    faultActive,
    output logic                    interlockActive,
    output logic                    triggerActive,
    output logic                    powerLossIn,
    output logic                    powerLossOut
);

    // ======================================================================
    // State and configuration link
    cdio_pkg::port_state_t st_ff;   // Registered state
    cdio_pkg::port_state_t nxt_st;  // Next state
    cdio_cfg_if            cfgBus();  // Link to the configuration store

    // ======================================================================
    // Helper functions

    // Logical value to connector level and back
    function automatic logic applyPol(input logic v, input logic activeLow);
        applyPol = v ^ activeLow;
    endfunction : applyPol

    // Functions that drive the pin
    function automatic logic isDriven(input cdio_pkg::func_t f);
        isDriven = (f == cdio_pkg::gp_output) || (f == cdio_pkg::gp_bidirectional) ||
                   (f == cdio_pkg::fault_mirror_output) ||
                   (f == cdio_pkg::power_loss_output) ||
                   (f == cdio_pkg::fault_gated_output);
    endfunction : isDriven

    // Functions whose readback is the pin, not the written value
    function automatic logic isSensed(input cdio_pkg::func_t f);
        isSensed = (f == cdio_pkg::gp_input) || (f == cdio_pkg::gp_bidirectional) ||
                   (f == cdio_pkg::fault_input) || (f == cdio_pkg::interlock_input) ||
                   (f == cdio_pkg::trigger_input) || (f == cdio_pkg::power_loss_input);
    endfunction : isSensed

    // Logical output value of a driven function
    function automatic logic outValue(input cdio_pkg::func_t f, input logic d,
                                      input logic flt, input logic pl);
        case (f)
            cdio_pkg::gp_output:           outValue = d;
            cdio_pkg::gp_bidirectional:    outValue = d;
            cdio_pkg::fault_mirror_output: outValue = flt;
            cdio_pkg::power_loss_output:   outValue = pl;
            cdio_pkg::fault_gated_output:  outValue = d & ~flt;
            default:                       outValue = 1'b0;
        endcase
    endfunction : outValue

    // ======================================================================
    // Configuration store; holds the retained image
    cdio_cfg_store u_store (
        .clk_sys   (clk_sys),
        .nrst      (nrst),
        .panelLock (panelLock),
        .nvImageIn (nvImageIn),
        .cfg       (cfgBus)
    );

    // Configuration write request straight from the register strobe
    assign cfgBus.wrReq = regWr && (regAddr == `OFS_CFG_WRITE);
    assign cfgBus.wrIdx = regWdata[`CFGF_IDX_MSB:`CFGF_IDX_LSB];
    assign cfgBus.wrCfg.isolated  = regWdata[`CFGF_ISO_BIT];
    assign cfgBus.wrCfg.activeLow = regWdata[`CFGF_POL_BIT];
    assign cfgBus.wrCfg.func = cdio_pkg::func_t'(regWdata[`CFGF_FUNC_MSB:`CFGF_FUNC_LSB]);

    // ======================================================================
    // Next-state logic
    always_comb begin
        cdio_pkg::bit_cfg_t c;      // Configuration of the bit in hand
        logic [15:0]        wrMask; // Bits a port write may change
        logic [15:0]        rdVal;  // Port readback word
        logic [15:0]        logIn;  // Polarity-corrected pin samples
        logic               lvl;    // Connector level wanted
        logic               fltAny;
        logic               ilkAny;
        logic               trgAny;
        logic               pwrAny;
        logic               accClr;
        logic               rejClr;
        c      = '0;
        wrMask = '0;
        rdVal  = '0;
        logIn  = '0;
        lvl    = 1'b0;
        fltAny = 1'b0;
        ilkAny = 1'b0;
        trgAny = 1'b0;
        pwrAny = 1'b0;
        accClr = 1'b0;
        rejClr = 1'b0;
        nxt_st = st_ff;

        // Pins are synchronous; one register stage for a stable view
        nxt_st.pinSamp = pinIn;

        // Per-bit decode of masks, readback and control inputs
        for (int i = 0; i < 16; i++) begin
            c = cfgBus.cfgVec[i];
            logIn[i] = applyPol(st_ff.pinSamp[i], c.activeLow);
            if (c.isolated) begin
                // Only the even bit carries the pair's value
                wrMask[i] = ~i[0];
                rdVal[i]  = i[0] ? 1'b0 : st_ff.portData[i];
            end else begin
                // Inputs keep their last stored value untouched
                wrMask[i] = isDriven(c.func);
                rdVal[i]  = isSensed(c.func) ? logIn[i]
                                             : st_ff.portData[i];
                fltAny = fltAny | ((c.func == cdio_pkg::fault_input) & logIn[i]);
                ilkAny = ilkAny | ((c.func == cdio_pkg::interlock_input) & logIn[i]);
                trgAny = trgAny | ((c.func == cdio_pkg::trigger_input) & logIn[i]);
                pwrAny = pwrAny | ((c.func == cdio_pkg::power_loss_input) & logIn[i]);
            end
        end

        // Control inputs for the instrument
        nxt_st.fault     = fltAny;
        nxt_st.interlock = ilkAny;
        nxt_st.trigger   = trgAny;
        nxt_st.pwrIn     = pwrAny;

        // Port data write; general reset clears data, never configuration
        if (genReset) begin
            nxt_st.portData = `PORT_DATA_RST;
        end else if (regWr && (regAddr == `OFS_PORT_DATA)) begin
            nxt_st.portData = (st_ff.portData & ~wrMask) |
                              (regWdata[15:0] & wrMask);
        end

        // Index for configuration readback
        if (regWr && (regAddr == `OFS_CFG_INDEX)) begin
            nxt_st.cfgIdx = regWdata[`CFGF_IDX_MSB:`CFGF_IDX_LSB];
        end

        // Power-loss state: a new save wins over a simultaneous clear
        if (pwrFailSaved) begin
            nxt_st.powerLoss = 1'b1;
        end else if (seqStart || restartRecall) begin
            nxt_st.powerLoss = 1'b0;
        end

        // Sticky error flags, write one to clear, a new event wins
        if (regWr && (regAddr == `OFS_STATUS)) begin
            accClr = regWdata[`STAT_ACC_BIT];
            rejClr = regWdata[`STAT_REJ_BIT];
        end
        nxt_st.accErr = (st_ff.accErr & ~accClr) | cfgBus.refused;
        nxt_st.cfgErr = (st_ff.cfgErr & ~rejClr) | cfgBus.rejected;

        // Pin drive from the new data word
        for (int i = 0; i < 16; i++) begin
            c = cfgBus.cfgVec[i];
            nxt_st.pinOut[i] = 1'b0;
            nxt_st.pinOe[i]  = 1'b0;
            if (c.isolated) begin
                // Even pin is the optocoupler anode, odd pin its return
                if (!i[0]) begin
                    lvl = applyPol(outValue(c.func, nxt_st.portData[i], st_ff.fault,
                                            st_ff.powerLoss), c.activeLow);
                    nxt_st.pinOut[i] = lvl;
                end
                nxt_st.pinOe[i] = 1'b1;
            end else if (isDriven(c.func)) begin
                // Open collector: high level releases, low level sinks
                lvl = applyPol(outValue(c.func, nxt_st.portData[i], st_ff.fault,
                                        st_ff.powerLoss), c.activeLow);
                nxt_st.pinOe[i] = ~lvl;
            end
        end

        // Read data valid only in the cycle after the strobe
        nxt_st.rdata = `RDATA_RST;
        if (regRd) begin
            case (regAddr)
                `OFS_PORT_DATA: begin
                    nxt_st.rdata[15:0] = rdVal;
                end
                `OFS_CFG_WRITE,
                `OFS_CFG_INDEX: begin
                    // Both show the indexed bit's configuration
                    c = cfgBus.cfgVec[st_ff.cfgIdx];
                    nxt_st.rdata[`CFGF_IDX_MSB:`CFGF_IDX_LSB]   = st_ff.cfgIdx;
                    nxt_st.rdata[`CFGF_FUNC_MSB:`CFGF_FUNC_LSB] = c.func;
                    nxt_st.rdata[`CFGF_POL_BIT] = c.activeLow;
                    nxt_st.rdata[`CFGF_ISO_BIT] = c.isolated;
                end
                `OFS_STATUS: begin
                    nxt_st.rdata[`STAT_ACC_BIT]   = st_ff.accErr;
                    nxt_st.rdata[`STAT_REJ_BIT]   = st_ff.cfgErr;
                    nxt_st.rdata[`STAT_PLOSS_BIT] = st_ff.powerLoss;
                    nxt_st.rdata[`STAT_LOCK_BIT]  = panelLock;
                    nxt_st.rdata[`STAT_FAULT_BIT] = st_ff.fault;
                end
                default: begin
                    // Unmapped addresses read as zero
                    nxt_st.rdata = `RDATA_RST;
                end
            endcase
        end
    end

    // ======================================================================
    // State register; power-on clears the power-loss output
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            st_ff.portData  <= `PORT_DATA_RST;
            st_ff.pinSamp   <= '0;
            st_ff.pinOut    <= '0;
            st_ff.pinOe     <= '0;
            st_ff.rdata     <= `RDATA_RST;
            st_ff.cfgIdx    <= `CFG_IDX_RST;
            st_ff.powerLoss <= 1'b0;
            st_ff.accErr    <= 1'b0;
            st_ff.cfgErr    <= 1'b0;
            st_ff.fault     <= 1'b0;
            st_ff.interlock <= 1'b0;
            st_ff.trigger   <= 1'b0;
            st_ff.pwrIn     <= 1'b0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ======================================================================
    // Outputs, all taken from flip-flops
    assign regRdata        = st_ff.rdata;
    assign pinOut          = st_ff.pinOut;
    assign pinOe           = st_ff.pinOe;
    assign faultActive     = st_ff.fault;
    assign interlockActive = st_ff.interlock;
    assign triggerActive   = st_ff.trigger;
    assign powerLossIn     = st_ff.pwrIn;
    assign powerLossOut    = st_ff.powerLoss;
    assign nvImageOut      = cfgBus.cfgVec; // Store flops, for write-back to retained memory

endmodule : configurable_digital_io_port

/* File: sim/cdio_ext_equipment.sv */
// External equipment on the connector: pull-ups plus optional drivers
`timescale 1ns/1ps
module cdio_ext_equipment (
    input  wire logic [15:0] pinOut,
    input  wire logic [15:0] pinOe,
    input  wire logic [15:0] extDrv,
    input  wire logic [15:0] extVal,
    output logic      [15:0] pinIn
);
    // ======================================================================
    // Wire level: a transistor that is on wins, else the driver, else pull-up
    assign pinIn = ~(pinOe & ~pinOut) & ((extDrv & extVal) | ~extDrv);
endmodule : cdio_ext_equipment

/* File: sim/configurable_digital_io_port_props.sv */
// Concurrent checks on the digital I/O port top-level ports
`timescale 1ns/1ps
module cdio_props (
    input wire logic               clk_sys,
    input wire logic               nrst,
    input wire logic [7:0]         regAddr,
    input wire logic               regWr,
    input wire logic               regRd,
    input wire logic [31:0]        regRdata,
    input wire logic [15:0]        pinOut,
    input wire logic [15:0]        pinOe,
    input wire logic               panelLock,
    input wire logic               genReset,
    input wire logic               pwrFailSaved,
    input wire logic               seqStart,
    input wire logic               restartRecall,
    input wire cdio_pkg::cfg_vec_t nvImageOut,
    input wire logic               powerLossOut
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    // ======================================================================
    // Masks of isolated and gp_input bits; pins lag config by one cycle
    logic [15:0] isoM;
    logic [15:0] inM;
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            isoM[i] = nvImageOut[i].isolated;
            inM[i] = nvImageOut[i].func == cdio_pkg::gp_input;
        end
    end
    // ======================================================================
    // Properties
    property p_rd; !regRd |=> regRdata == 32'h0; endproperty
    property p_up; regRd && regAddr == 8'h00 |=> regRdata[31:16] == 16'h0; endproperty
    property p_set; pwrFailSaved |=> powerLossOut; endproperty
    property p_clr; (seqStart || restartRecall) && !pwrFailSaved |=> !powerLossOut; endproperty
    property p_lock; panelLock && regWr && regAddr == 8'h04 |=> $stable(nvImageOut); endproperty
    property p_grst; genReset && !regWr |=> $stable(nvImageOut); endproperty
    property p_oc; ((pinOe & pinOut) & ~isoM & ~$past(isoM)) == 16'h0; endproperty
    property p_in; (pinOe & inM & $past(inM)) == 16'h0; endproperty
    a_rd: assert property (p_rd) else $error("read data outside read slot");
    a_up: assert property (p_up) else $error("upper data bits set");
    a_set: assert property (p_set) else $error("power loss output not set");
    a_clr: assert property (p_clr) else $error("power loss output not cleared");
    a_lock: assert property (p_lock) else $error("locked config changed");
    a_grst: assert property (p_grst) else $error("config changed by reset");
    a_oc: assert property (p_oc) else $error("chassis pin driven high");
    a_in: assert property (p_in) else $error("input pin driven");
    c_pl: cover property (pwrFailSaved ##1 powerLossOut);
    c_lk: cover property (panelLock && regWr && regAddr == 8'h04);
    c_rd: cover property (regRd && regAddr == 8'h00);
endmodule : cdio_props

/* File: sim/configurable_digital_io_port_test.sv */
// Self-checking bench for the configurable digital I/O port
`timescale 1ns/1ps
module configurable_digital_io_port_test;
    logic clk_sys = 1'b0, nrst = 1'b0, regWr = 1'b0, regRd = 1'b0, panelLock = 1'b0;
    logic genReset = 1'b0, pwrFailSaved = 1'b0, seqStart = 1'b0, restartRecall = 1'b0;
    logic [7:0]  regAddr = 8'h00;
    logic [31:0] regWdata = 32'h0, regRdata, d;
    logic [15:0] extDrv = 16'h0, extVal = 16'h0, wd = 16'h0, pinIn, pinOut, pinOe;
    logic faultActive, interlockActive, triggerActive, powerLossIn, powerLossOut, pl = 1'b0;
    cdio_pkg::cfg_vec_t img, nvImageOut;
    int n_errors = 0, n_compared = 0, seed = 35, cyc = 0;
    // Boot image {iso, low-true, func}; bits 8/9 are one isolated pair
    localparam logic [5:0] CFGT [16] = '{6'h01, 6'h11, 6'h00, 6'h10, 6'h02, 6'h03, 6'h04,
        6'h09, 6'h21, 6'h21, 6'h12, 6'h05, 6'h08, 6'h16, 6'h07, 6'h19};
    localparam logic [2:0] PLS [5] = '{3'b100, 3'b010, 3'b100, 3'b001, 3'b110};
    always #2 clk_sys = ~clk_sys;
    configurable_digital_io_port dut_u (.clk_sys(clk_sys), .nrst(nrst), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
        .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .panelLock(panelLock),
        .genReset(genReset), .pwrFailSaved(pwrFailSaved), .seqStart(seqStart),
        .restartRecall(restartRecall), .nvImageIn(img), .nvImageOut(nvImageOut),
        .faultActive(faultActive), .interlockActive(interlockActive),
        .triggerActive(triggerActive), .powerLossIn(powerLossIn), .powerLossOut(powerLossOut));
    cdio_ext_equipment ext_u (.pinOut(pinOut), .pinOe(pinOe), .extDrv(extDrv),
        .extVal(extVal), .pinIn(pinIn));
    // ======================================================================
    // Expected {level, readback, enable, out} from config, data and pins
    function automatic logic [63:0] expect_io(input cdio_pkg::cfg_vec_t c,
            input logic [15:0] w, input logic f);
        logic [15:0] lv, rb, oe, ou;
        logic v, o;
        for (int i = 0; i < 16; i++) begin
            o = 1'b1;
            case (c[i].func)
                cdio_pkg::gp_output, cdio_pkg::gp_bidirectional: v = w[i];
                cdio_pkg::fault_mirror_output: v = f;
                cdio_pkg::power_loss_output: v = pl;
                cdio_pkg::fault_gated_output: v = w[i] & ~f;
                default: begin
                    v = 1'b0;
                    o = 1'b0;
                end
            endcase
            oe[i] = c[i].isolated | (o & ~(v ^ c[i].activeLow));
            ou[i] = c[i].isolated & ~i[0] & (v ^ c[i].activeLow);
            lv[i] = (oe[i] & ~ou[i]) ? 1'b0 : (extDrv[i] ? extVal[i] : 1'b1);
            if (c[i].isolated) begin
                rb[i] = ~i[0] & w[i];
            end else begin
                rb[i] = (o && c[i].func != cdio_pkg::gp_bidirectional) ? w[i]
                        : lv[i] ^ c[i].activeLow;
            end
        end
        return {lv, rb, oe, ou};
    endfunction : expect_io
    // ======================================================================
    // Bus cycles and comparisons
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        regAddr <= a;
        regWdata <= v;
        regWr <= 1'b1;
        @(posedge clk_sys);
        regWr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk_sys);
        regRd <= 1'b0;
        #1 v = regRdata;
        @(posedge clk_sys);
    endtask : rd
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic chk_cfg(input cdio_pkg::cfg_vec_t g, input cdio_pkg::cfg_vec_t e);
        n_compared++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk_cfg
    task automatic check_all();
        logic [63:0] e;
        logic f;
        repeat (5) @(posedge clk_sys);
        f = extDrv[5] ? extVal[5] : 1'b1;
        e = expect_io(img, wd, f);
        rd(8'h00, d);
        chk({16'h0, pinOe}, {16'h0, e[31:16]});
        chk({16'h0, pinOut}, {16'h0, e[15:0]});
        chk(d, {16'h0, e[47:32]});
        chk({28'h0, faultActive, interlockActive, triggerActive, powerLossIn},
            {28'h0, f, e[59], ~e[61], e[62]});
        chk({31'h0, powerLossOut}, {31'h0, pl});
    endtask : check_all
    task automatic rand_rounds(input int n);
        logic [31:0] r;
        for (int k = 0; k < n; k++) begin
            r = $random(seed);
            wd = (k == 0) ? 16'hFFFF : (k == 1) ? 16'h0000 : r[15:0];
            extDrv <= (k == 2) ? 16'h0000 : 16'($random(seed));
            extVal <= 16'($random(seed));
            wr(8'h00, {r[31:16], wd});
            check_all();
        end
    endtask : rand_rounds
    task automatic end_of_test();
        if (n_errors == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_of_test
    // ======================================================================
    // Hang guard
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 5000) begin
            n_errors++;
            end_of_test();
        end
    end
    // ======================================================================
    // Main sequence
    initial begin
        for (int i = 0; i < 16; i++) img[i] = cdio_pkg::bit_cfg_t'(CFGT[i]);
        repeat (10) @(posedge clk_sys);
        nrst <= 1'b1;
        @(posedge clk_sys);
        rand_rounds(30);
        for (int j = 0; j < 5; j++) begin
            {pwrFailSaved, seqStart, restartRecall} <= PLS[j];
            @(posedge clk_sys);
            {pwrFailSaved, seqStart, restartRecall} <= 3'b000;
            pl = PLS[j][2];
            check_all();
        end
        wr(8'h04, 32'h200);
        genReset <= 1'b1;
        @(posedge clk_sys);
        genReset <= 1'b0;
        wd = 16'h0000;
        check_all();
        chk_cfg(nvImageOut, img);
        panelLock <= 1'b1;
        wr(8'h04, 32'h8);
        repeat (2) @(posedge clk_sys);
        rd(8'h0C, d);
        chk(d & 32'h3, 32'h3);
        chk_cfg(nvImageOut, img);
        rd(8'h08, d);
        chk(d, 32'h10);
        panelLock <= 1'b0;
        wr(8'h04, 32'h18);
        img[8] = cdio_pkg::bit_cfg_t'(6'h01);
        img[9] = cdio_pkg::bit_cfg_t'(6'h12);
        @(posedge clk_sys);
        chk_cfg(nvImageOut, img);
        rand_rounds(8);
        rd(8'h10, d);
        chk(d, 32'h0);
        end_of_test();
    end
endmodule : configurable_digital_io_port_test

bind configurable_digital_io_port cdio_props chk_u (.clk_sys(clk_sys), .nrst(nrst),
    .regAddr(regAddr), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .pinOut(pinOut),
    .pinOe(pinOe), .panelLock(panelLock), .genReset(genReset), .pwrFailSaved(pwrFailSaved),
    .seqStart(seqStart), .restartRecall(restartRecall), .nvImageOut(nvImageOut),
    .powerLossOut(powerLossOut));
